//--- hdl/ncs_selector.sv
// network command source selector: chooses per command whether terminals,
// the serial link, or both drive the drive controller's command inputs.
// assumes a plain register port, synchronous inputs, one clock, and a
// drive-stopped indication from the operation logic.
// What this block does
// (RULE_01) separate start and speed source selections
// (RULE_02) unassigned switch: sources follow source parameters
// (RULE_03) switch off: terminals only, link ignored
// (RULE_04) switch level sampled only while stopped
// (RULE_05) switch off: link reset request rejected
// (RULE_06) host maps switch via code 67
// (RULE_07) protect value 2: run writes, apply at stop
// (RULE_08) combined, external, network acceptance per function
// (RULE_09) run permit always from terminal
// (RULE_10) pid valid follows speed source
// (RULE_11) output stop becomes interlock in mode 7 when no panel interlock terminal is assigned
// (RULE_12) switching only in network operation mode
// (RULE_13) switch on: sources equal parameter selections
// (RULE_14) effective sources reload only when stopped
module ncs_selector #(
  parameter int unsigned NUM_TERM = 5
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  input wire logic drive_stopped_i,
  input wire logic net_mode_i,
  input wire logic [NUM_TERM-1:0] term_i,
  input wire logic net_fwd_i,
  input wire logic net_rev_i,
  input wire logic [2:0] net_speed_i,
  input wire logic net_pid_valid_i,
  input wire logic net_output_stop_i,
  input wire logic net_reset_i,
  output logic fwd_o,
  output logic rev_o,
  output logic [2:0] speed_sel_o,
  output logic pid_valid_o,
  output logic run_permit_o,
  output logic output_stop_o,
  output logic panel_interlock_o,
  output logic drive_reset_o
);

  // parameter registers
  logic [7:0] op_src;                  // operation_source_param
  logic [7:0] spd_src;                 // speed_source_param
  logic [7:0] wprot;                   // write_protect_param
  logic [7:0] opmode;                  // operation_mode_param
  logic [NUM_TERM*8-1:0] tfn;          // terminal function codes

  // effective state, refreshed only in stopped cycles
  logic eff_op_net;                    // start commands from the link
  logic eff_spd_net;                   // speed commands from the link
  logic eff_sw_asg;                    // switch function was assigned
  logic eff_sw_lvl;                    // switch level taken at stop

  // decoded terminal functions
  logic [ncs_pkg::FI_NUM-1:0] lvl;
  logic [ncs_pkg::FI_NUM-1:0] asg;

  // combinational helpers
  logic src_wr_ok;
  logic next_sw_on;
  logic next_op_net;
  logic next_spd_net;
  logic reset_block;
  logic ilock_mode;
  logic [7:0] status;
  ncs_pkg::ncs_src_t op_sel;
  ncs_pkg::ncs_src_t spd_sel;

  // select a command from terminal, link, or both
  // with both, either side can assert the command but neither can cancel the other,
  // so a stuck link bit cannot be overridden from the terminals in that mode
  function automatic logic pick(input ncs_pkg::ncs_src_t src, input logic t, input logic n);
    case (src)
      ncs_pkg::NCS_SRC_TERM: pick = t;
      ncs_pkg::NCS_SRC_NET: pick = n;
      default: pick = t | n;
    endcase
  endfunction

  // terminal function decoding
  ncs_term_map #(
    .NUM_TERM(NUM_TERM)
  ) u_map (
    .tfn_i(tfn),
    .term_i(term_i),
    .fn_lvl_o(lvl),
    .fn_asg_o(asg)
  );

  // source parameters are refused while running unless protection allows it
  assign src_wr_ok = drive_stopped_i || (wprot == ncs_pkg::WPROT_RUN_WRITE); // [RULE_07]

  // parameter register writes
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_src <= ncs_pkg::RST_OP_SRC;
      spd_src <= ncs_pkg::RST_SPD_SRC;
      wprot <= ncs_pkg::RST_WPROT;
      opmode <= ncs_pkg::RST_OPMODE;
      tfn <= {NUM_TERM{ncs_pkg::RST_TFN}};
    end else if (reg_we_i) begin
      // the two selections are independent registers
      if (reg_addr_i == ncs_pkg::ADDR_OP_SRC && src_wr_ok) begin // [RULE_01]
        op_src <= reg_wdata_i;
      end
      if (reg_addr_i == ncs_pkg::ADDR_SPD_SRC && src_wr_ok) begin // [RULE_07]
        spd_src <= reg_wdata_i;
      end
      if (reg_addr_i == ncs_pkg::ADDR_WPROT) begin
        wprot <= reg_wdata_i;
      end
      if (reg_addr_i == ncs_pkg::ADDR_OPMODE) begin
        opmode <= reg_wdata_i;
      end
      // terminal codes sit at consecutive offsets
      for (int unsigned t = 0; t < NUM_TERM; t++) begin
        if (reg_addr_i == 4'(ncs_pkg::ADDR_TFN_FIRST + t)) begin
          tfn[t*8 +: 8] <= reg_wdata_i;
        end
      end
    end
  end

  // pending source selection from parameters and the switch level
  always_comb begin
    // an unassigned switch behaves like a switch held on
    next_sw_on = !asg[ncs_pkg::FI_SW] || lvl[ncs_pkg::FI_SW]; // [RULE_02] [RULE_13]
    // outside network mode everything but the link reset stays on the terminals
    next_op_net = net_mode_i && next_sw_on && (op_src == ncs_pkg::SRC_NET); // [RULE_12]
    next_spd_net = net_mode_i && next_sw_on && (spd_src == ncs_pkg::SRC_NET); // [RULE_03]
  end

  // effective selections; held while running so a run never changes source
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eff_op_net <= 1'b0;
      eff_spd_net <= 1'b0;
      eff_sw_asg <= 1'b0;
      eff_sw_lvl <= 1'b0;
    end else if (drive_stopped_i) begin // [RULE_14] [RULE_04]
      eff_op_net <= next_op_net;
      eff_spd_net <= next_spd_net;
      eff_sw_asg <= asg[ncs_pkg::FI_SW];
      eff_sw_lvl <= lvl[ncs_pkg::FI_SW];
    end
  end

  // per-function routing
  always_comb begin
    // the link reset is refused while an assigned switch is off
    reset_block = eff_sw_asg && !eff_sw_lvl; // [RULE_05]
    // output stop turns into an interlock only without an interlock terminal
    ilock_mode = (opmode == ncs_pkg::OPMODE_PANEL_ILOCK) && !asg[ncs_pkg::FI_PANEL]; // [RULE_11]
    op_sel = eff_op_net ? ncs_pkg::NCS_SRC_NET : ncs_pkg::NCS_SRC_TERM;
    spd_sel = eff_spd_net ? ncs_pkg::NCS_SRC_NET : ncs_pkg::NCS_SRC_TERM;
  end

  // start commands follow the operation source
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fwd_o <= 1'b0;
      rev_o <= 1'b0;
    end else begin
      fwd_o <= pick(op_sel, lvl[ncs_pkg::FI_FWD], net_fwd_i); // [RULE_08]
      rev_o <= pick(op_sel, lvl[ncs_pkg::FI_REV], net_rev_i); // [RULE_08]
    end
  end

  // speed related commands follow the speed source
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      speed_sel_o <= 3'h0;
      pid_valid_o <= 1'b0;
    end else begin
      speed_sel_o[0] <= pick(spd_sel, lvl[ncs_pkg::FI_LOW], net_speed_i[0]);
      speed_sel_o[1] <= pick(spd_sel, lvl[ncs_pkg::FI_MID], net_speed_i[1]);
      speed_sel_o[2] <= pick(spd_sel, lvl[ncs_pkg::FI_HIGH], net_speed_i[2]);
      pid_valid_o <= pick(spd_sel, lvl[ncs_pkg::FI_PID], net_pid_valid_i); // [RULE_10]
    end
  end

  // run permit is a safety input, so the link can never drive it
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_permit_o <= 1'b0;
    end else begin
      run_permit_o <= lvl[ncs_pkg::FI_RUN]; // [RULE_09]
    end
  end

  // output stop is combined under link control, else terminal only; in interlock mode it stays low
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output_stop_o <= 1'b0;
      panel_interlock_o <= 1'b0;
    end else if (ilock_mode) begin
      output_stop_o <= 1'b0;
      panel_interlock_o <= lvl[ncs_pkg::FI_OSTOP]; // [RULE_11]
    end else begin
      output_stop_o <= pick(eff_op_net ? ncs_pkg::NCS_SRC_BOTH : ncs_pkg::NCS_SRC_TERM,
                            lvl[ncs_pkg::FI_OSTOP], net_output_stop_i); // [RULE_08]
      panel_interlock_o <= lvl[ncs_pkg::FI_PANEL];
    end
  end

  // reset from terminal always, from the link only when not blocked
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drive_reset_o <= 1'b0;
    end else begin
      drive_reset_o <= lvl[ncs_pkg::FI_RESET] || (net_reset_i && !reset_block); // [RULE_05]
    end
  end

  // status word shows the sources in force
  always_comb begin
    status = 8'h00;
    status[ncs_pkg::ST_OP_NET] = eff_op_net;
    status[ncs_pkg::ST_SPD_NET] = eff_spd_net;
    status[ncs_pkg::ST_SW_LEVEL] = eff_sw_lvl;
    status[ncs_pkg::ST_SW_ASSIGNED] = eff_sw_asg;
    status[ncs_pkg::ST_STOPPED] = drive_stopped_i;
  end

  // read data valid one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      if (reg_addr_i == ncs_pkg::ADDR_OP_SRC) begin
        reg_rdata_o <= op_src;
      end else if (reg_addr_i == ncs_pkg::ADDR_SPD_SRC) begin
        reg_rdata_o <= spd_src;
      end else if (reg_addr_i == ncs_pkg::ADDR_WPROT) begin
        reg_rdata_o <= wprot;
      end else if (reg_addr_i == ncs_pkg::ADDR_OPMODE) begin
        reg_rdata_o <= opmode;
      end else if (reg_addr_i >= ncs_pkg::ADDR_TFN_FIRST &&
                   reg_addr_i <= ncs_pkg::ADDR_TFN_LAST) begin
        // terminal codes; index is offset from the first terminal
        reg_rdata_o <= tfn[(reg_addr_i - ncs_pkg::ADDR_TFN_FIRST)*8 +: 8];
      end else if (reg_addr_i == ncs_pkg::ADDR_STATUS) begin
        reg_rdata_o <= status;
      end else begin
        // unmapped offsets read as zero
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // sources never move while the drive runs
  AST_EFF_HOLD_RUN: assert property ( // [RULE_14]
    !drive_stopped_i |=> (eff_op_net == $past(eff_op_net)) &&
                         (eff_spd_net == $past(eff_spd_net)))
    else $error("effective source changed while running");

  // a stopped cycle loads the pending selection
  AST_EFF_LOAD_STOP: assert property ( // [RULE_13]
    drive_stopped_i |=> (eff_op_net == $past(next_op_net)) &&
                        (eff_spd_net == $past(next_spd_net)))
    else $error("effective source not loaded at stop");

  // a switch level changed while running is taken only after the stop
  AST_SW_LEVEL_RUN: assert property ( // [RULE_04]
    !drive_stopped_i ##1 !drive_stopped_i |-> eff_sw_lvl == $past(eff_sw_lvl))
    else $error("switch level sampled during run");

  // switch off forces terminal sources
  AST_SW_OFF_TERM: assert property ( // [RULE_03]
    (eff_sw_asg && !eff_sw_lvl) |-> !eff_op_net && !eff_spd_net)
    else $error("link source active with switch off");

  // with no switch assigned the parameters alone decide
  AST_UNASSIGNED: assert property ( // [RULE_02]
    drive_stopped_i && net_mode_i && !asg[ncs_pkg::FI_SW] |=>
      eff_op_net == ($past(op_src) == ncs_pkg::SRC_NET) &&
      eff_spd_net == ($past(spd_src) == ncs_pkg::SRC_NET))
    else $error("unassigned switch did not follow parameters");

  // outside network mode the link controls no command but the reset
  AST_NOT_NET_MODE: assert property ( // [RULE_12]
    drive_stopped_i && !net_mode_i |=> !eff_op_net && !eff_spd_net)
    else $error("link source outside network mode");

  // start and speed selections are independent
  AST_SRC_SPLIT: assert property ( // [RULE_01]
    drive_stopped_i && next_sw_on && net_mode_i && op_src == ncs_pkg::SRC_NET &&
    spd_src != ncs_pkg::SRC_NET |=> eff_op_net && !eff_spd_net)
    else $error("start and speed sources not separate");

  // link reset refused while the switch is off
  AST_RESET_REJECT: assert property ( // [RULE_05]
    reset_block && net_reset_i && !lvl[ncs_pkg::FI_RESET] |=> !drive_reset_o)
    else $error("link reset passed with switch off");

  // a running write without protection value 2 leaves the parameter
  AST_WRITE_BLOCK: assert property ( // [RULE_07]
    reg_we_i && reg_addr_i == ncs_pkg::ADDR_OP_SRC && !drive_stopped_i &&
    wprot != ncs_pkg::WPROT_RUN_WRITE |=> op_src == $past(op_src))
    else $error("source write accepted while running");

  // run permit ignores the link entirely
  AST_RUN_PERMIT: assert property ( // [RULE_09]
    eff_op_net |=> run_permit_o == $past(lvl[ncs_pkg::FI_RUN]))
    else $error("run permit not from terminal");

  // pid valid taken from the link under link speed control
  AST_PID_SRC: assert property ( // [RULE_10]
    eff_spd_net |=> pid_valid_o == $past(net_pid_valid_i))
    else $error("pid valid not from link");

  // interlock mode silences output stop
  AST_ILOCK: assert property ( // [RULE_11]
    ilock_mode |=> !output_stop_o && panel_interlock_o == $past(lvl[ncs_pkg::FI_OSTOP]))
    else $error("interlock mode routing wrong");

  // combined output stop accepts the link
  AST_COMBINED: assert property ( // [RULE_08]
    eff_op_net && !ilock_mode && net_output_stop_i |=> output_stop_o)
    else $error("combined output stop missed link");

  // main scenarios
  COV_LINK_START: cover property (drive_stopped_i && next_op_net ##1 eff_op_net);
  COV_RESET_REJECT: cover property (reset_block && net_reset_i);
  COV_RUN_WRITE: cover property (reg_we_i && !drive_stopped_i && src_wr_ok ##[1:20]
                                 drive_stopped_i);
  COV_ILOCK: cover property (ilock_mode && lvl[ncs_pkg::FI_OSTOP]);

endmodule // ncs_selector

//--- hdl/ncs_term_map.sv
// terminal function mapper: turns the per-terminal function codes and the
// terminal levels into one level and one assigned flag per function.
// assumes terminal levels are already synchronous to the clock.
module ncs_term_map #(
  parameter int unsigned NUM_TERM = 5
) (
  input wire logic [NUM_TERM*8-1:0] tfn_i,                // function code per terminal
  input wire logic [NUM_TERM-1:0] term_i,                 // terminal levels
  output logic [ncs_pkg::FI_NUM-1:0] fn_lvl_o,            // function active
  output logic [ncs_pkg::FI_NUM-1:0] fn_asg_o             // function assigned
);

  // code that belongs to each function index
  function automatic logic [7:0] fi_code(input int unsigned idx);
    case (idx)
      ncs_pkg::FI_LOW: fi_code = ncs_pkg::FN_LOW;
      ncs_pkg::FI_MID: fi_code = ncs_pkg::FN_MID;
      ncs_pkg::FI_HIGH: fi_code = ncs_pkg::FN_HIGH;
      ncs_pkg::FI_RUN: fi_code = ncs_pkg::FN_RUN_PERMIT;
      ncs_pkg::FI_PANEL: fi_code = ncs_pkg::FN_PANEL_ILOCK;
      ncs_pkg::FI_PID: fi_code = ncs_pkg::FN_PID_VALID;
      ncs_pkg::FI_OSTOP: fi_code = ncs_pkg::FN_OUT_STOP;
      ncs_pkg::FI_FWD: fi_code = ncs_pkg::FN_FWD;
      ncs_pkg::FI_REV: fi_code = ncs_pkg::FN_REV;
      ncs_pkg::FI_RESET: fi_code = ncs_pkg::FN_RESET;
      default: fi_code = ncs_pkg::FN_SRC_SWITCH;
    endcase
  endfunction

  // several terminals may carry one function; their levels are or-ed
  always_comb begin
    fn_lvl_o = '0;
    fn_asg_o = '0;
    for (int unsigned f = 0; f < ncs_pkg::FI_NUM; f++) begin
      for (int unsigned t = 0; t < NUM_TERM; t++) begin
        if (tfn_i[t*8 +: 8] == fi_code(f)) begin // [RULE_06]
          fn_asg_o[f] = 1'b1;
          fn_lvl_o[f] = fn_lvl_o[f] | term_i[t];
        end
      end
    end
  end

endmodule // ncs_term_map

//--- pkg/ncs_pkg.sv
// package of the network command source selector: register map, reset values,
// function codes and source encodings.
// assumes a byte-wide register port and a single 250 MHz clock.
package ncs_pkg;

  // register port widths
  localparam int unsigned REG_AW = 4;
  localparam int unsigned REG_DW = 8;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] ADDR_OP_SRC = 4'h0;      // operation_source_param
  localparam logic [3:0] ADDR_SPD_SRC = 4'h1;     // speed_source_param
  localparam logic [3:0] ADDR_WPROT = 4'h2;       // write_protect_param
  localparam logic [3:0] ADDR_OPMODE = 4'h3;      // operation_mode_param
  localparam logic [3:0] ADDR_TFN_FIRST = 4'h4;   // terminal_function_param_first
  localparam logic [3:0] ADDR_TFN_LAST = 4'h8;    // terminal_function_param_last
  localparam logic [3:0] ADDR_STATUS = 4'h9;      // read-only status

  // reset values
  localparam logic [7:0] RST_OP_SRC = 8'h00;
  localparam logic [7:0] RST_SPD_SRC = 8'h00;
  localparam logic [7:0] RST_WPROT = 8'h00;
  localparam logic [7:0] RST_OPMODE = 8'h00;
  localparam logic [7:0] RST_TFN = 8'hFF;         // no function assigned

  // source parameter values
  localparam logic [7:0] SRC_NET = 8'h00;         // network_source
  localparam logic [7:0] WPROT_RUN_WRITE = 8'h02; // writes allowed while running
  localparam logic [7:0] OPMODE_PANEL_ILOCK = 8'h07;

  // terminal function codes
  localparam logic [7:0] FN_LOW = 8'h00;
  localparam logic [7:0] FN_MID = 8'h01;
  localparam logic [7:0] FN_HIGH = 8'h02;
  localparam logic [7:0] FN_RUN_PERMIT = 8'h0A;   // run_permit_input
  localparam logic [7:0] FN_PANEL_ILOCK = 8'h0C;  // panel_interlock_input
  localparam logic [7:0] FN_PID_VALID = 8'h0E;    // pid_valid_input
  localparam logic [7:0] FN_OUT_STOP = 8'h18;     // output_stop_input
  localparam logic [7:0] FN_FWD = 8'h3C;
  localparam logic [7:0] FN_REV = 8'h3D;
  localparam logic [7:0] FN_RESET = 8'h3E;
  localparam logic [7:0] FN_SRC_SWITCH = 8'h43;   // source_switch_input

  // index of each decoded function in the mapper's vectors
  localparam int unsigned FI_LOW = 0;
  localparam int unsigned FI_MID = 1;
  localparam int unsigned FI_HIGH = 2;
  localparam int unsigned FI_RUN = 3;
  localparam int unsigned FI_PANEL = 4;
  localparam int unsigned FI_PID = 5;
  localparam int unsigned FI_OSTOP = 6;
  localparam int unsigned FI_FWD = 7;
  localparam int unsigned FI_REV = 8;
  localparam int unsigned FI_RESET = 9;
  localparam int unsigned FI_SW = 10;
  localparam int unsigned FI_NUM = 11;

  // status register bit positions
  localparam int unsigned ST_OP_NET = 0;
  localparam int unsigned ST_SPD_NET = 1;
  localparam int unsigned ST_SW_LEVEL = 2;
  localparam int unsigned ST_SW_ASSIGNED = 3;
  localparam int unsigned ST_STOPPED = 4;

  // where a command may come from
  typedef enum logic [1:0] {NCS_SRC_TERM, NCS_SRC_NET, NCS_SRC_BOTH} ncs_src_t;

endpackage

//--- test/ncs_far_side.sv
// far side model: the host computer on the register port and the control terminals.
// assumes the bench calls its tasks from one process; every change follows a rising edge.
module ncs_far_side (
  input wire logic ref_clk_i,
  output logic [3:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  input wire logic [7:0] reg_rdata_i,
  output logic [4:0] term_o,
  output logic [7:0] link_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle host, all terminals and link commands low from time zero
  initial begin
    reg_addr_o = 4'h0;
    reg_wdata_o = 8'h00;
    reg_we_o = 1'b0;
    reg_re_o = 1'b0;
    term_o = 5'h00;
    link_o = 8'h00;
  end

  // one write cycle: strobe, address and data stand together for one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_we_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_we_o <= 1'b0;
  endtask

  // one read cycle: data stand only in the cycle after the strobe, taken 1 ns after its edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_re_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_re_o <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask

  // terminal 4 carries the switch when mapped, otherwise it is left unassigned
  task automatic map_switch(input logic on);
    wr(ncs_pkg::ADDR_TFN_LAST, on ? ncs_pkg::FN_SRC_SWITCH : ncs_pkg::RST_TFN);
  endtask

  // terminal levels, held until changed
  task automatic set_term(input logic [4:0] v);
    @(posedge ref_clk_i);
    term_o <= v;
  endtask

  // link levels: [0] fwd, [1] rev, [4:2] speed, [5] pid, [6] stop, [7] reset
  task automatic set_link(input logic [7:0] v);
    @(posedge ref_clk_i);
    link_o <= v;
  endtask
endmodule // ncs_far_side

//--- test/tb_network_command_source_selector.sv
// self-checking bench of the command source selector, reset values first, then table rows, then edge cases.
// assumes terminals 0..3 carry forward, low speed, run permit and pid valid.
module tb_network_command_source_selector;
  timeunit 1ns;
  timeprecision 100ps;

  // one row: params, then flags {asg, lvl, netm, t, n, e_op, e_spd}
  typedef struct packed {logic [7:0] op; logic [7:0] spd; logic [6:0] f;} ncs_row_t;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic stopped = 1'b1; // drive idle unless a test runs it
  logic net_mode = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, link, d;
  logic we, re;
  logic [4:0] term;
  logic fwd_o, rev_o, pid_valid_o, run_permit_o, output_stop_o, panel_interlock_o;
  logic drive_reset_o;
  logic [2:0] speed_sel_o;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic asg, lvl, netm, t, n, eo, es;
  logic [7:0] lpat [2] = '{8'hA5, 8'h5A}; // link patterns, each bit high in one and low in the other
  ncs_row_t rows [8] = '{
    '{8'h00, 8'h00, 7'h17}, '{8'h01, 8'h00, 7'h15}, '{8'h00, 8'h02, 7'h16},
    '{8'h00, 8'h00, 7'h77}, '{8'h00, 8'h00, 7'h54}, '{8'h00, 8'h00, 7'h04},
    '{8'h00, 8'h00, 7'h58}, '{8'h01, 8'h01, 7'h78}};

  always #2 clk = ~clk;

  ncs_far_side far (.ref_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_we_o(we),
    .reg_re_o(re), .reg_rdata_i(rdata), .term_o(term), .link_o(link));

  ncs_selector #(.NUM_TERM(5)) dut (.ref_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .drive_stopped_i(stopped), .net_mode_i(net_mode), .term_i(term), .net_fwd_i(link[0]),
    .net_rev_i(link[1]), .net_speed_i(link[4:2]), .net_pid_valid_i(link[5]),
    .net_output_stop_i(link[6]), .net_reset_i(link[7]), .fwd_o(fwd_o), .rev_o(rev_o),
    .speed_sel_o(speed_sel_o), .pid_valid_o(pid_valid_o), .run_permit_o(run_permit_o),
    .output_stop_o(output_stop_o), .panel_interlock_o(panel_interlock_o),
    .drive_reset_o(drive_reset_o));

  // one comparison, counted; case inequality so an unknown never matches
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // reload edge plus output edge, with a spare one, then sample settled values
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // reset values, unmapped and read-only places
    far.rd(ncs_pkg::ADDR_TFN_FIRST, d);
    chk("tfn reset", ncs_pkg::RST_TFN, d);
    far.rd(ncs_pkg::ADDR_WPROT, d);
    chk("wprot reset", ncs_pkg::RST_WPROT, d);
    far.rd(4'hA, d);
    chk("unmapped", 8'h00, d);
    far.wr(ncs_pkg::ADDR_STATUS, 8'hFF);
    far.rd(ncs_pkg::ADDR_STATUS, d);
    chk("status reset", 8'h10, d);
    far.wr(ncs_pkg::ADDR_TFN_FIRST, ncs_pkg::FN_FWD);
    far.wr(ncs_pkg::ADDR_TFN_FIRST + 4'h1, ncs_pkg::FN_LOW);
    far.wr(ncs_pkg::ADDR_TFN_FIRST + 4'h2, ncs_pkg::FN_RUN_PERMIT);
    far.wr(ncs_pkg::ADDR_TFN_FIRST + 4'h3, ncs_pkg::FN_PID_VALID);
    // table rows, all taken while stopped so every write lands
    foreach (rows[i]) begin
      {asg, lvl, netm, t, n, eo, es} = rows[i].f;
      far.wr(ncs_pkg::ADDR_OP_SRC, rows[i].op);
      far.wr(ncs_pkg::ADDR_SPD_SRC, rows[i].spd);
      far.map_switch(asg);
      far.set_term({lvl, t, t, t, t});
      far.set_link({8{n}});
      @(posedge clk);
      net_mode <= netm;
      settle();
      chk("fwd", eo ? n : t, fwd_o);
      chk("rev", eo & n, rev_o);
      chk("speed", es ? {3{n}} : {2'b00, t}, speed_sel_o);
      chk("pid", es ? n : t, pid_valid_o);
      chk("permit", t, run_permit_o);
      chk("ostop", eo & n, output_stop_o);
      chk("link reset", n & ~(asg & ~lvl), drive_reset_o);
      far.rd(ncs_pkg::ADDR_STATUS, d);
      chk("status", {3'h0, 1'b1, asg, asg & lvl, es, eo}, d);
    end
    // both sources on the link, every link bit driven high in one pattern and low in the other
    far.wr(ncs_pkg::ADDR_OP_SRC, 8'h00);
    far.wr(ncs_pkg::ADDR_SPD_SRC, 8'h00);
    foreach (lpat[i]) begin
      far.set_link(lpat[i]);
      settle();
      chk("fwd bit", lpat[i][0], fwd_o);
      chk("rev bit", lpat[i][1], rev_o);
      chk("speed bits", lpat[i][4:2], speed_sel_o);
      chk("pid bit", lpat[i][5], pid_valid_o);
      chk("ostop bit", lpat[i][6], output_stop_o);
      chk("reset bit", lpat[i][7], drive_reset_o);
    end
    // a reset terminal acts even with the switch off and the link quiet
    far.wr(ncs_pkg::ADDR_TFN_FIRST + 4'h2, ncs_pkg::FN_RESET);
    far.set_link(8'h00);
    far.set_term(5'h04);
    settle();
    chk("term reset", 8'h01, drive_reset_o);
    chk("permit unmapped", 8'h00, run_permit_o);
    // changes while running wait for the stop
    far.wr(ncs_pkg::ADDR_OP_SRC, 8'h00);
    far.wr(ncs_pkg::ADDR_SPD_SRC, 8'h00);
    far.map_switch(1'b1);
    far.set_term(5'h10);
    far.set_link(8'hFF);
    settle();
    stopped <= 1'b0;
    far.wr(ncs_pkg::ADDR_OP_SRC, 8'h01);
    far.rd(ncs_pkg::ADDR_OP_SRC, d);
    chk("op refused", 8'h00, d);
    far.wr(ncs_pkg::ADDR_WPROT, ncs_pkg::WPROT_RUN_WRITE);
    far.wr(ncs_pkg::ADDR_OP_SRC, 8'h01);
    far.rd(ncs_pkg::ADDR_OP_SRC, d);
    chk("op accepted", 8'h01, d);
    far.set_term(5'h00);
    settle();
    chk("fwd held", 8'h01, fwd_o);
    far.rd(ncs_pkg::ADDR_STATUS, d);
    chk("status run", 8'h0F, d);
    stopped <= 1'b1;
    settle();
    chk("fwd stop", 8'h00, fwd_o);
    far.rd(ncs_pkg::ADDR_STATUS, d);
    chk("status stop", 8'h18, d);
    // output stop: combined, then interlock in mode 7, then back once interlock is mapped
    far.map_switch(1'b0);
    far.wr(ncs_pkg::ADDR_OP_SRC, 8'h00);
    far.wr(ncs_pkg::ADDR_TFN_FIRST + 4'h1, ncs_pkg::FN_OUT_STOP);
    far.set_link(8'h00);
    far.set_term(5'h02);
    settle();
    chk("ostop term", 8'h01, output_stop_o);
    far.set_term(5'h00);
    far.set_link(8'h40);
    settle();
    chk("ostop link", 8'h01, output_stop_o);
    far.wr(ncs_pkg::ADDR_OPMODE, ncs_pkg::OPMODE_PANEL_ILOCK);
    far.set_term(5'h02);
    settle();
    chk("ostop mode7", 8'h00, output_stop_o);
    chk("ilock mode7", 8'h01, panel_interlock_o);
    far.wr(ncs_pkg::ADDR_TFN_FIRST + 4'h3, ncs_pkg::FN_PANEL_ILOCK);
    settle();
    chk("ostop mapped", 8'h01, output_stop_o);
    chk("ilock mapped", 8'h00, panel_interlock_o);
    // reset with the drive stopped: outputs fall at once, parameters return to reset values
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk("ostop in reset", 8'h00, output_stop_o);
    rstn <= 1'b1;
    far.rd(ncs_pkg::ADDR_OPMODE, d);
    chk("opmode reset", ncs_pkg::RST_OPMODE, d);
    close_out();
  end
endmodule // tb_network_command_source_selector
